/* verilog/tmr_cfg.svh */
/*
 Register offsets, field positions, reset values and codes of the 8-bit timer.
 Assumes it is included by bare name from every file that needs a constant.
*/
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ==========================================================
// Register map (byte addresses, 32-bit aligned words)
`define TMR_OFS_CTL_A 8'h24
`define TMR_OFS_CTL_B 8'h28
`define TMR_OFS_CNT 8'h2C
`define TMR_OFS_OCR_A 8'h30
`define TMR_OFS_OCR_B 8'h34
`define TMR_OFS_FLAG 8'h38

// ==========================================================
// Fields and values
`define TMR_RST_BYTE 8'h00
`define TMR_PAD 24'h000000
`define TMR_MAX 8'hFF
`define TMR_BOTTOM 8'h00
`define TMR_ONE 8'h01
`define TMR_OM_A 7:6
`define TMR_OM_B 5:4
`define TMR_WGM_LO 1:0
`define TMR_WGM_HI 3
`define TMR_CS 2:0
`define TMR_FLG_OCB 2
`define TMR_FLG_OCA 1
`define TMR_FLG_TOV 0
`define TMR_CTL_A_WMASK 8'hF3

// ==========================================================
// Waveform modes, clock selects, output modes
`define TMR_WGM_NORM 3'h0
`define TMR_WGM_PC_FF 3'h1
`define TMR_WGM_CTC 3'h2
`define TMR_WGM_FAST_FF 3'h3
`define TMR_WGM_PC_OCA 3'h5
`define TMR_WGM_FAST_OCA 3'h7
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7
`define TMR_OM_OFF 2'h0
`define TMR_OM_TOG 2'h1
`define TMR_OM_CLR 2'h2
`define TMR_OM_SET 2'h3
`define TMR_PS_ONE 10'h001
`define TMR_PS_M8 10'h007
`define TMR_PS_M64 10'h03F
`define TMR_PS_M256 10'h0FF
`define TMR_PS_M1024 10'h3FF

`endif

/* verilog/tmr_pkg.sv */
/*
 Types shared by the timer core and its waveform output stage.
 Assumes tmr_cfg.svh is compiled alongside; holds no logic.
*/
package tmr_pkg;

	// ==========================================================
	// Counting class decoded from the waveform mode
	typedef enum logic [3:0] {
		TMR_CLS_NORM = 4'h1,
		TMR_CLS_CTC = 4'h2,
		TMR_CLS_FAST = 4'h4,
		TMR_CLS_PC = 4'h8
	} tmr_cls_e;

	// ==========================================================
	// Events handed to each waveform output stage
	typedef struct packed {
		logic match;
		logic down;
		logic wrap;
		logic pc_top;
		logic cmp_top;
	} tmr_evt_s;

	typedef struct packed {
		logic oc;
	} tmr_wave_s;

	typedef struct packed {
		logic [7:0] ctl_a;
		logic wgm_hi;
		logic [2:0] cs;
		logic [7:0] cnt;
		logic down;
		logic blk;
		logic [7:0] ocra_buf;
		logic [7:0] ocrb_buf;
		logic [7:0] ocra;
		logic [7:0] ocrb;
		logic [2:0] flg;
		logic [9:0] ps;
		logic ext_s1;
		logic ext_s2;
		logic ext_s3;
		logic [31:0] rdata;
		logic err;
		logic pin_a;
		logic pin_a_oe_b;
		logic pin_b;
		logic pin_b_oe_b;
	} tmr_state_s;

endpackage

/* verilog/tmr_wave.sv */
/*
 One compare output stage: drives the compare output level from match and count events.
 Assumes events arrive already qualified by the timer tick from the counter core.
*/
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tmr_wave (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire tmr_pkg::tmr_cls_e cls,
	input wire logic [1:0] om,
	input wire logic tog_ok,
	input wire tmr_pkg::tmr_evt_s evt,
	output logic oc
);

	tmr_pkg::tmr_wave_s s_q;
	tmr_pkg::tmr_wave_s s_d;

	// ==========================================================
	// Output level update
	always_comb begin
		s_d = s_q;
		case (cls)
			tmr_pkg::TMR_CLS_NORM, tmr_pkg::TMR_CLS_CTC: begin
				if (evt.match) begin
					case (om)
						`TMR_OM_TOG: s_d.oc = !s_q.oc;
						`TMR_OM_CLR: s_d.oc = 1'h0;
						`TMR_OM_SET: s_d.oc = 1'h1;
						default: s_d.oc = s_q.oc;
					endcase
				end
			end
			tmr_pkg::TMR_CLS_FAST: begin
				if (evt.match && om == `TMR_OM_TOG && tog_ok) begin
					s_d.oc = !s_q.oc;
				end
				if (om[1]) begin
					// A compare value at TOP loses its match; the level is set at BOTTOM only.
					if (evt.match && !evt.cmp_top) begin
						s_d.oc = (om == `TMR_OM_SET);
					end
					if (evt.wrap) begin
						s_d.oc = (om == `TMR_OM_CLR);
					end
				end
			end
			tmr_pkg::TMR_CLS_PC: begin
				if (evt.match && om == `TMR_OM_TOG && tog_ok) begin
					s_d.oc = !s_q.oc;
				end
				if (om[1]) begin
					if (evt.match && !evt.cmp_top) begin
						s_d.oc = evt.down ? (om == `TMR_OM_CLR) : (om == `TMR_OM_SET);
					end
					if (evt.pc_top && evt.cmp_top) begin
						s_d.oc = (om == `TMR_OM_CLR);
					end
				end
			end
			default: s_d = s_q;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= tmr_pkg::tmr_wave_s'(1'h0);
		end else begin
			s_q <= s_d;
		end
	end

	assign oc = s_q.oc;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	property p_nonpwm_clr;
		evt.match && om == `TMR_OM_CLR && (cls == tmr_pkg::TMR_CLS_NORM || cls == tmr_pkg::TMR_CLS_CTC) |=> !oc;
	endproperty
	a_nonpwm_clr: assert property (p_nonpwm_clr) else $error("clear on match missed");

	property p_fast_bottom;
		evt.wrap && om == `TMR_OM_CLR && cls == tmr_pkg::TMR_CLS_FAST |=> oc;
	endproperty
	a_fast_bottom: assert property (p_fast_bottom) else $error("set at bottom missed");

	property p_pc_up_match;
		cls == tmr_pkg::TMR_CLS_PC && evt.match && !evt.cmp_top && !evt.down && om == `TMR_OM_CLR |=> !oc;
	endproperty
	a_pc_up_match: assert property (p_pc_up_match) else $error("up-count clear missed");

	property p_pc_top;
		cls == tmr_pkg::TMR_CLS_PC && evt.pc_top && evt.cmp_top && om == `TMR_OM_SET |=> !oc;
	endproperty
	a_pc_top: assert property (p_pc_top) else $error("top special case wrong");

endmodule

/* verilog/tmr_core.sv */
/*
 8-bit timer core: APB registers, prescaler, counter, compare buffers, flags and output pins.
 Assumes an APB master on core_clk, port data and direction from same-clock logic,
 and an asynchronous external count pin.
*/
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module tmr_core (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_count_pin,
	input wire logic port_data_a,
	input wire logic port_dir_a,
	input wire logic port_data_b,
	input wire logic port_dir_b,
	input wire logic vec_ack_ovf,
	input wire logic vec_ack_a,
	input wire logic vec_ack_b,
	output logic compare_out_a,
	output logic compare_out_a_oe_b,
	output logic compare_out_b,
	output logic compare_out_b_oe_b,
	output logic match_flag_a,
	output logic match_flag_b,
	output logic overflow_flag
);

	tmr_pkg::tmr_state_s s_q;
	tmr_pkg::tmr_state_s s_d;
	tmr_pkg::tmr_cls_e cls;
	tmr_pkg::tmr_evt_s evt_a;
	tmr_pkg::tmr_evt_s evt_b;
	logic [2:0] waveform_mode;
	logic [1:0] chan_a_output_mode;
	logic [1:0] chan_b_output_mode;
	logic [7:0] top;
	logic timer_tick_enable;
	logic at_top;
	logic at_bot;
	logic match_a;
	logic match_b;
	logic wrap;
	logic pc_top;
	logic ovf;
	logic setup;
	logic wr_acc;
	logic [2:0] flg_clr;
	logic oc_a;
	logic oc_b;

	// ==========================================================
	// Decoding helpers
	function automatic tmr_pkg::tmr_cls_e f_cls(input logic [2:0] w);
		case (w)
			`TMR_WGM_CTC: f_cls = tmr_pkg::TMR_CLS_CTC;
			`TMR_WGM_FAST_FF, `TMR_WGM_FAST_OCA: f_cls = tmr_pkg::TMR_CLS_FAST;
			`TMR_WGM_PC_FF, `TMR_WGM_PC_OCA: f_cls = tmr_pkg::TMR_CLS_PC;
			default: f_cls = tmr_pkg::TMR_CLS_NORM;
		endcase
	endfunction

	function automatic logic f_mapped(input logic [7:0] a);
		f_mapped = (a == `TMR_OFS_CTL_A) || (a == `TMR_OFS_CTL_B) || (a == `TMR_OFS_CNT) ||
			(a == `TMR_OFS_OCR_A) || (a == `TMR_OFS_OCR_B) || (a == `TMR_OFS_FLAG);
	endfunction

	function automatic logic f_tick(input logic [2:0] cs, input logic [9:0] ps, input logic rise,
		input logic fall);
		case (cs)
			`TMR_CS_DIV1: f_tick = 1'h1;
			`TMR_CS_DIV8: f_tick = (ps & `TMR_PS_M8) == `TMR_PS_M8;
			`TMR_CS_DIV64: f_tick = (ps & `TMR_PS_M64) == `TMR_PS_M64;
			`TMR_CS_DIV256: f_tick = (ps & `TMR_PS_M256) == `TMR_PS_M256;
			`TMR_CS_DIV1024: f_tick = (ps & `TMR_PS_M1024) == `TMR_PS_M1024;
			`TMR_CS_EXT_FALL: f_tick = fall;
			`TMR_CS_EXT_RISE: f_tick = rise;
			default: f_tick = 1'h0;
		endcase
	endfunction

	// ==========================================================
	// Mode, TOP and events
	assign waveform_mode = {s_q.wgm_hi, s_q.ctl_a[`TMR_WGM_LO]};
	assign chan_a_output_mode = s_q.ctl_a[`TMR_OM_A];
	assign chan_b_output_mode = s_q.ctl_a[`TMR_OM_B];
	assign cls = f_cls(waveform_mode);

	always_comb begin
		case (waveform_mode)
			`TMR_WGM_CTC, `TMR_WGM_PC_OCA, `TMR_WGM_FAST_OCA: top = s_q.ocra;
			default: top = `TMR_MAX;
		endcase
	end

	// The prescaler and the pin edge only make a one-cycle enable; no second clock exists.
	assign timer_tick_enable = f_tick(s_q.cs, s_q.ps, s_q.ext_s2 && !s_q.ext_s3,
		!s_q.ext_s2 && s_q.ext_s3);
	assign at_top = s_q.cnt == top;
	assign at_bot = s_q.cnt == `TMR_BOTTOM;
	assign match_a = timer_tick_enable && !s_q.blk && s_q.cnt == s_q.ocra;
	assign match_b = timer_tick_enable && !s_q.blk && s_q.cnt == s_q.ocrb;
	assign wrap = timer_tick_enable && cls == tmr_pkg::TMR_CLS_FAST && at_top;
	assign pc_top = timer_tick_enable && cls == tmr_pkg::TMR_CLS_PC && !s_q.down && at_top;

	always_comb begin
		case (waveform_mode)
			`TMR_WGM_NORM, `TMR_WGM_CTC, `TMR_WGM_FAST_FF: ovf = timer_tick_enable && s_q.cnt == `TMR_MAX;
			`TMR_WGM_FAST_OCA: ovf = timer_tick_enable && at_top;
			`TMR_WGM_PC_FF, `TMR_WGM_PC_OCA: ovf = timer_tick_enable && s_q.down && at_bot;
			default: ovf = 1'h0;
		endcase
	end

	assign evt_a = '{match: match_a, down: s_q.down && !at_bot, wrap: wrap, pc_top: pc_top,
		cmp_top: s_q.ocra == top};
	assign evt_b = '{match: match_b, down: s_q.down && !at_bot, wrap: wrap, pc_top: pc_top,
		cmp_top: s_q.ocrb == top};

	// ==========================================================
	// APB access
	// Read data is captured in the setup cycle, so every access ends in its first access cycle.
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite && !s_q.err;
	assign pready = psel && penable;
	assign pslverr = psel && penable && s_q.err;
	assign prdata = s_q.rdata;

	always_comb begin
		flg_clr = {vec_ack_b, vec_ack_a, vec_ack_ovf};
		if (wr_acc && paddr == `TMR_OFS_FLAG) begin
			flg_clr = flg_clr | pwdata[2:0];
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.ext_s1 = ext_count_pin;
		s_d.ext_s2 = s_q.ext_s1;
		s_d.ext_s3 = s_q.ext_s2;
		s_d.ps = (s_q.cs == `TMR_CS_STOP) ? 10'h000 : s_q.ps + `TMR_PS_ONE;

		if (timer_tick_enable) begin
			s_d.blk = 1'h0;
			case (cls)
				tmr_pkg::TMR_CLS_CTC, tmr_pkg::TMR_CLS_FAST: begin
					s_d.cnt = at_top ? `TMR_BOTTOM : s_q.cnt + `TMR_ONE;
				end
				tmr_pkg::TMR_CLS_PC: begin
					if (!s_q.down && at_top) begin
						s_d.down = 1'h1;
						s_d.cnt = s_q.cnt - `TMR_ONE;
					end else if (s_q.down && at_bot) begin
						s_d.down = 1'h0;
						s_d.cnt = s_q.cnt + `TMR_ONE;
					end else begin
						s_d.cnt = s_q.down ? s_q.cnt - `TMR_ONE : s_q.cnt + `TMR_ONE;
					end
				end
				default: s_d.cnt = s_q.cnt + `TMR_ONE;
			endcase
		end
		if (cls != tmr_pkg::TMR_CLS_PC) begin
			s_d.down = 1'h0;
		end

		// Compare buffers: straight through, or loaded at BOTTOM or TOP.
		case (cls)
			tmr_pkg::TMR_CLS_FAST: begin
				if (wrap) begin
					s_d.ocra = s_q.ocra_buf;
					s_d.ocrb = s_q.ocrb_buf;
				end
			end
			tmr_pkg::TMR_CLS_PC: begin
				if (pc_top) begin
					s_d.ocra = s_q.ocra_buf;
					s_d.ocrb = s_q.ocrb_buf;
				end
			end
			default: begin
				s_d.ocra = s_q.ocra_buf;
				s_d.ocrb = s_q.ocrb_buf;
			end
		endcase

		// A hardware set in the same cycle as a clear wins, so no event is lost.
		s_d.flg = (s_q.flg & ~flg_clr) | {match_b, match_a, ovf};

		if (setup) begin
			s_d.err = !f_mapped(paddr);
			case (paddr)
				`TMR_OFS_CTL_A: s_d.rdata = {`TMR_PAD, s_q.ctl_a};
				`TMR_OFS_CTL_B: s_d.rdata = {`TMR_PAD, 4'h0, s_q.wgm_hi, s_q.cs};
				`TMR_OFS_CNT: s_d.rdata = {`TMR_PAD, s_q.cnt};
				`TMR_OFS_OCR_A: s_d.rdata = {`TMR_PAD, s_q.ocra_buf};
				`TMR_OFS_OCR_B: s_d.rdata = {`TMR_PAD, s_q.ocrb_buf};
				`TMR_OFS_FLAG: s_d.rdata = {`TMR_PAD, 5'h00, s_q.flg};
				default: s_d.rdata = {`TMR_PAD, `TMR_RST_BYTE};
			endcase
		end

		if (wr_acc) begin
			case (paddr)
				`TMR_OFS_CTL_A: s_d.ctl_a = pwdata[7:0] & `TMR_CTL_A_WMASK;
				`TMR_OFS_CTL_B: begin
					s_d.wgm_hi = pwdata[`TMR_WGM_HI];
					s_d.cs = pwdata[`TMR_CS];
				end
				`TMR_OFS_CNT: begin
					// A counter write suppresses the match on the next tick.
					s_d.cnt = pwdata[7:0];
					s_d.blk = 1'h1;
				end
				`TMR_OFS_OCR_A: s_d.ocra_buf = pwdata[7:0];
				`TMR_OFS_OCR_B: s_d.ocrb_buf = pwdata[7:0];
				default: s_d.err = s_q.err;
			endcase
		end

		s_d.pin_a = (chan_a_output_mode != `TMR_OM_OFF) ? oc_a : port_data_a;
		s_d.pin_a_oe_b = !port_dir_a;
		s_d.pin_b = (chan_b_output_mode != `TMR_OM_OFF) ? oc_b : port_data_b;
		s_d.pin_b_oe_b = !port_dir_b;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '{default: '0, pin_a_oe_b: 1'h1, pin_b_oe_b: 1'h1};
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Waveform output stages
	tmr_wave u_wave_a (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.cls(cls),
		.om(chan_a_output_mode),
		.tog_ok(s_q.wgm_hi),
		.evt(evt_a),
		.oc(oc_a)
	);

	tmr_wave u_wave_b (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.cls(cls),
		.om(chan_b_output_mode),
		.tog_ok(1'h0),
		.evt(evt_b),
		.oc(oc_b)
	);

	assign compare_out_a = s_q.pin_a;
	assign compare_out_a_oe_b = s_q.pin_a_oe_b;
	assign compare_out_b = s_q.pin_b;
	assign compare_out_b_oe_b = s_q.pin_b_oe_b;
	assign match_flag_a = s_q.flg[`TMR_FLG_OCA];
	assign match_flag_b = s_q.flg[`TMR_FLG_OCB];
	assign overflow_flag = s_q.flg[`TMR_FLG_TOV];

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	logic cnt_wr;
	assign cnt_wr = wr_acc && paddr == `TMR_OFS_CNT;

	property p_tick_div1;
		s_q.cs == `TMR_CS_DIV1 |-> timer_tick_enable;
	endproperty
	a_tick_div1: assert property (p_tick_div1) else $error("undivided tick missing");

	property p_ctc_clear;
		waveform_mode == `TMR_WGM_CTC && match_a && !cnt_wr |=> s_q.cnt == `TMR_BOTTOM && match_flag_a;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("clear on match failed");

	property p_pin_a;
		chan_a_output_mode != `TMR_OM_OFF |=> compare_out_a == $past(oc_a);
	endproperty
	a_pin_a: assert property (p_pin_a) else $error("pin A not routed");

	property p_pin_b;
		chan_b_output_mode == `TMR_OM_OFF |=> compare_out_b == $past(port_data_b) &&
			compare_out_b_oe_b == !$past(port_dir_b);
	endproperty
	a_pin_b: assert property (p_pin_b) else $error("pin B port path wrong");

	property p_rsv_read;
		setup && paddr == `TMR_OFS_CTL_A ##1 pready |-> prdata[3:2] == 2'h0;
	endproperty
	a_rsv_read: assert property (p_rsv_read) else $error("reserved bits not zero");

	property p_pc_ovf;
		cls == tmr_pkg::TMR_CLS_PC && timer_tick_enable && s_q.down && at_bot |=> overflow_flag && !s_q.down;
	endproperty
	a_pc_ovf: assert property (p_pc_ovf) else $error("bottom overflow missed");

	property p_top_fixed;
		waveform_mode == `TMR_WGM_FAST_FF |-> top == `TMR_MAX;
	endproperty
	a_top_fixed: assert property (p_top_fixed) else $error("fixed top wrong");

	property p_fast_wrap;
		wrap && !cnt_wr |=> s_q.cnt == `TMR_BOTTOM;
	endproperty
	a_fast_wrap: assert property (p_fast_wrap) else $error("fast wrap failed");

	sequence s_pc_turn;
		pc_top && !cnt_wr && top != `TMR_BOTTOM;
	endsequence
	sequence s_pc_after(logic [7:0] t);
		s_q.down && s_q.cnt == t - `TMR_ONE;
	endsequence
	property p_pc_turn;
		logic [7:0] t;
		(s_pc_turn, t = top) |=> s_pc_after(t);
	endproperty
	a_pc_turn: assert property (p_pc_turn) else $error("direction turn wrong");

	property p_stop;
		s_q.cs == `TMR_CS_STOP && !cnt_wr |=> $stable(s_q.cnt);
	endproperty
	a_stop: assert property (p_stop) else $error("stopped counter moved");

	property p_ovf_clr;
		overflow_flag && vec_ack_ovf && !ovf |=> !overflow_flag;
	endproperty
	a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");

	property p_set_wins;
		match_b |=> match_flag_b;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("match B flag lost");

endmodule

/* tb/timer8_waveform_output_control_tb.sv */
/*
 Self-checking bench for the timer core: APB register access, pin routing, flags and PWM duty.
 Assumes tmr_core and tmr_cfg.svh from verilog/ are compiled first; assertions live in the design.
*/
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module timer8_waveform_output_control_tb;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic port_data_a = 1'b0;
	logic port_dir_a = 1'b0;
	logic port_data_b = 1'b0;
	logic port_dir_b = 1'b0;
	logic vec_ack_ovf = 1'b0;
	logic vec_ack_b = 1'b0;
	logic ext_pin = 1'b0;
	logic compare_out_a;
	logic compare_out_a_oe_b;
	logic compare_out_b;
	logic compare_out_b_oe_b;
	logic match_flag_a;
	logic match_flag_b;
	logic overflow_flag;
	logic meas_on = 1'b0;
	logic on_q = 1'b0;
	logic [2:0] meas_sel = 3'h0;
	logic [6:0] outs;
	logic probe;
	logic [32:0] rq[$];
	int dq[$];
	int hi_cnt = 0;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	int seed;
	int ocra;
	int ocrb;
	int m;
	logic pc;
	logic inv;

	tmr_core dut_u (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_count_pin(ext_pin), .port_data_a(port_data_a), .port_dir_a(port_dir_a),
		.port_data_b(port_data_b), .port_dir_b(port_dir_b), .vec_ack_ovf(vec_ack_ovf),
		.vec_ack_a(1'b0), .vec_ack_b(vec_ack_b), .compare_out_a(compare_out_a),
		.compare_out_a_oe_b(compare_out_a_oe_b), .compare_out_b(compare_out_b),
		.compare_out_b_oe_b(compare_out_b_oe_b), .match_flag_a(match_flag_a),
		.match_flag_b(match_flag_b), .overflow_flag(overflow_flag));

	always #10 core_clk = ~core_clk;

	assign outs = {overflow_flag, match_flag_b, match_flag_a, compare_out_b_oe_b, compare_out_a_oe_b,
		compare_out_b, compare_out_a};
	assign probe = outs[meas_sel];

	// ==========================================================
	// Comparison and closing
	task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: read got %h want %h", $time, g, e);
		end
	endtask

	task automatic cmp_cnt(input int e, input int g);
		n_tests++;
		if (g != e) begin
			mismatches++;
			$display("unexpected at %0t: high cycles %0d want %0d", $time, g, e);
		end
	endtask

	task automatic wrap_up();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Output monitor: pops the oldest note whenever a result appears
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			$display("unexpected at %0t: timeout", $time);
			wrap_up();
		end
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (rq.size() > 0) begin
				cmp_rd(rq.pop_front(), {pslverr, prdata});
			end else begin
				mismatches++;
				$display("unexpected at %0t: read with no expectation", $time);
			end
		end
		if (meas_on) begin
			hi_cnt = hi_cnt + ((probe === 1'b1) ? 1 : 0);
			on_q = 1'b1;
		end else if (on_q) begin
			cmp_cnt(dq.pop_front(), hi_cnt);
			hi_cnt = 0;
			on_q = 1'b0;
		end
	end

	// ==========================================================
	// APB master and measurement tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h000000, d});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic er);
		rq.push_back({er, 24'h000000, e});
		apb(1'b0, a, 32'h0);
	endtask

	// Counts high samples of the chosen output over exactly len edges.
	task automatic meas(input logic [2:0] s, input int len, input int e);
		dq.push_back(e);
		meas_sel <= s;
		meas_on <= 1'b1;
		repeat (len) @(posedge core_clk);
		meas_on <= 1'b0;
		@(posedge core_clk);
	endtask

	function automatic int duty(input int ocr, input logic p, input logic i);
		if (p) begin
			return i ? 510 - 2 * ocr : 2 * ocr;
		end
		return i ? 255 - ocr : ocr + 1;
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		seed = $urandom(32'hB538);
		rd(`TMR_OFS_CTL_A, 8'h00, 1'b0);
		rd(`TMR_OFS_CTL_B, 8'h00, 1'b0);
		rd(`TMR_OFS_FLAG, 8'h00, 1'b0);
		rd(8'h3C, 8'h00, 1'b1);
		wr(`TMR_OFS_CTL_A, 8'hFF);
		rd(`TMR_OFS_CTL_A, 8'hF3, 1'b0);
		wr(`TMR_OFS_CTL_A, 8'h00);
		// Output mode 00 leaves the pins to the ordinary port data.
		port_data_a <= 1'($urandom_range(1, 0));
		port_data_b <= 1'($urandom_range(1, 0));
		port_dir_a <= 1'($urandom_range(1, 0));
		port_dir_b <= 1'($urandom_range(1, 0));
		repeat (3) @(posedge core_clk);
		meas(3'h0, 32, port_data_a ? 32 : 0);
		meas(3'h1, 32, port_data_b ? 32 : 0);
		meas(3'h2, 32, port_dir_a ? 0 : 32);
		meas(3'h3, 32, port_dir_b ? 0 : 32);
		// Normal mode overflow at MAX, then cleared by the vector acknowledge.
		wr(`TMR_OFS_OCR_A, 8'hE0);
		wr(`TMR_OFS_OCR_B, 8'hE0);
		wr(`TMR_OFS_CNT, 8'hF0);
		wr(`TMR_OFS_CTL_B, 8'h01);
		repeat (40) @(posedge core_clk);
		wr(`TMR_OFS_CTL_B, 8'h00);
		rd(`TMR_OFS_FLAG, 8'h01, 1'b0);
		meas(3'h6, 4, 4);
		vec_ack_ovf <= 1'b1;
		@(posedge core_clk);
		vec_ack_ovf <= 1'b0;
		rd(`TMR_OFS_FLAG, 8'h00, 1'b0);
		// Prescaled ticks: one count per divide period, the prescaler restarts from a stop.
		for (int c = 2; c < 6; c++) begin
			m = $urandom_range(4, 1);
			wr(`TMR_OFS_CNT, 8'h00);
			wr(`TMR_OFS_CTL_B, 8'(c));
			repeat (m * ((c == 2) ? 8 : (c == 3) ? 64 : (c == 4) ? 256 : 1024)) @(posedge core_clk);
			wr(`TMR_OFS_CTL_B, 8'h00);
			rd(`TMR_OFS_CNT, 8'(m), 1'b0);
		end
		// External pin edges, rising first and then falling.
		for (int e = 0; e < 2; e++) begin
			m = $urandom_range(20, 1);
			wr(`TMR_OFS_CNT, 8'h00);
			wr(`TMR_OFS_CTL_B, e ? 8'h06 : 8'h07);
			repeat (m) begin
				ext_pin <= 1'b1;
				repeat (3) @(posedge core_clk);
				ext_pin <= 1'b0;
				repeat (3) @(posedge core_clk);
			end
			repeat (5) @(posedge core_clk);
			wr(`TMR_OFS_CTL_B, 8'h00);
			rd(`TMR_OFS_CNT, 8'(m), 1'b0);
		end
		// Clear-on-match with toggling A: both match flags, B pin left off.
		ocra = $urandom_range(100, 20);
		ocrb = $urandom_range(ocra - 1, 0);
		wr(`TMR_OFS_OCR_A, 8'(ocra));
		wr(`TMR_OFS_OCR_B, 8'(ocrb));
		wr(`TMR_OFS_CNT, 8'h00);
		wr(`TMR_OFS_CTL_A, 8'h42);
		wr(`TMR_OFS_CTL_B, 8'h01);
		repeat (4 * (ocra + 1)) @(posedge core_clk);
		meas(3'h0, 2 * (ocra + 1), ocra + 1);
		wr(`TMR_OFS_CTL_B, 8'h00);
		rd(`TMR_OFS_FLAG, 8'h06, 1'b0);
		meas(3'h4, 4, 4);
		meas(3'h5, 4, 4);
		vec_ack_b <= 1'b1;
		@(posedge core_clk);
		vec_ack_b <= 1'b0;
		rd(`TMR_OFS_FLAG, 8'h02, 1'b0);
		wr(`TMR_OFS_FLAG, 8'h07);
		rd(`TMR_OFS_FLAG, 8'h00, 1'b0);
		// Fast and phase-correct PWM with fixed TOP, both polarities.
		for (int k = 0; k < 4; k++) begin
			pc = k[1];
			inv = k[0];
			ocra = (k == 2) ? 255 : $urandom_range(255, 0);
			ocrb = (k == 0) ? 255 : $urandom_range(255, 0);
			wr(`TMR_OFS_CTL_B, 8'h00);
			wr(`TMR_OFS_CTL_A, 8'h00);
			wr(`TMR_OFS_OCR_A, 8'(ocra));
			wr(`TMR_OFS_OCR_B, 8'(ocrb));
			wr(`TMR_OFS_CTL_A, {1'b1, inv, 1'b1, inv, 2'b00, pc ? 2'b01 : 2'b11});
			wr(`TMR_OFS_CTL_B, 8'h01);
			repeat (1100) @(posedge core_clk);
			meas(3'h0, pc ? 510 : 256, duty(ocra, pc, inv));
			meas(3'h1, pc ? 510 : 256, duty(ocrb, pc, inv));
		end
		// Fast PWM with TOP from compare A: A toggles, B non-inverting.
		wr(`TMR_OFS_CTL_B, 8'h00);
		wr(`TMR_OFS_CTL_A, 8'h00);
		ocra = $urandom_range(200, 40);
		ocrb = $urandom_range(ocra - 1, 0);
		wr(`TMR_OFS_OCR_A, 8'(ocra));
		wr(`TMR_OFS_OCR_B, 8'(ocrb));
		wr(`TMR_OFS_CTL_A, 8'h63);
		wr(`TMR_OFS_CTL_B, 8'h09);
		repeat (4 * (ocra + 1) + 10) @(posedge core_clk);
		meas(3'h0, 2 * (ocra + 1), ocra + 1);
		meas(3'h1, ocra + 1, ocrb + 1);
		wrap_up();
	end
endmodule
